// File: hdl/clr_dec_pkg.sv
/*
 * shared constants and carrier types for the clear / decrement execution unit.
 * assumes a single 50 MHz clock and a register file that reads combinationally and writes on the edge.
 */
package clr_dec_pkg;
   // -------------------------------------------------------------
   // opcodes
   // -------------------------------------------------------------
   localparam logic [7:0] OPC_ZERO_FILL_R    = 8'hB0;  // zero fill, register
   localparam logic [7:0] OPC_ZERO_FILL_PTR  = 8'hB1;  // zero fill, pointer register
   localparam logic [7:0] OPC_MINUS_ONE_R    = 8'h00;  // minus one, register
   localparam logic [7:0] OPC_MINUS_ONE_PTR  = 8'h01;  // minus one, pointer register
   // -------------------------------------------------------------
   // instruction shape and values
   // -------------------------------------------------------------
   localparam int         INSTR_BYTES        = 2;      // opcode plus destination
   localparam int         INSTR_CYCLES       = 4;      // cycles per instruction
   localparam logic [3:0] WORK_PREFIX        = 4'hC;   // 4-bit upper-nibble code marking a working reg
   localparam logic [7:0] BYTE_ZERO          = 8'h00;
   localparam logic [7:0] BYTE_ONE           = 8'h01;
   localparam int         MSB                = 7;      // bit 7 is the sign, bit 0 the lsb
   // flag positions in the flag byte
   localparam int         FLAG_C             = 7;
   localparam int         FLAG_Z             = 6;
   localparam int         FLAG_S             = 5;
   localparam int         FLAG_V             = 4;
   localparam int         FLAG_D             = 3;
   localparam int         FLAG_H             = 2;

   // seven explicit operand addressing modes
   typedef enum logic [2:0] {
      MODE_REGISTER,
      MODE_POINTER_REGISTER,
      MODE_INDEXED,
      MODE_ABSOLUTE_ADDRESS,
      MODE_PC_OFFSET,
      MODE_LITERAL_OPERAND,
      MODE_POINTER_ADDRESS
   } addr_mode_t;

   // register-file write request
   typedef struct packed {
      logic       we;
      logic [7:0] addr;
      logic [7:0] data;
   } rf_write_t;

   // register pair view: two adjacent registers, even one is the high byte
   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
   } reg_pair_t;
endpackage

// File: hdl/clear_decrement_exec_unit.sv
/*
 * decode and execute for the zero fill and minus one instructions.
 * assumes program bytes arrive with a valid strobe, and that the register
 * file answers a read address with data in the same cycle (combinational).
 */
// How it works
// RL1: byte bits numbered 7 to 0, lsb 0
// RL2: operand by 8-bit address or working nibble
// RL3: adjacent registers pair into 16-bit values
// RL4: peripherals live in register address space
// RL5: decoder knows seven explicit addressing modes; only register and pointer register are decoded
// RL6: zero fill writes zero, flags unchanged
// RL7: opcode B0 register form, 2 bytes, 4 cycles
// RL8: opcode B1 zeroes pointed register, pointer kept
// RL9: minus one writes destination minus one
// RL10: minus one sets Z S V, keeps C D H
// RL11: opcodes 00 and 01, 2 bytes, 4 cycles
// RL12: wraps modulo 256, V on 80 to 7F
// RL13: untouched flags kept, write within cycle count
`timescale 1ns/1ps
module clear_decrement_exec_unit #(
   parameter int DATA_W = 8   // register width
) (
   input  wire logic                        clk,
   input  wire logic                        reset,
   input  wire logic                        prog_valid,    // program byte present
   input  wire logic [7:0]                  prog_byte,     // program memory byte
   output logic                             prog_ready,    // byte consumed this cycle
   input  wire logic [3:0]                  work_base,     // working register block base
   output logic [7:0]                       rf_rd_addr,    // register file read address
   input  wire logic [7:0]                  rf_rd_data,    // register file read data
   output clr_dec_pkg::rf_write_t           rf_wr,         // register file write
   input  wire logic [7:0]                  flags_in,      // current flag byte
   output logic [7:0]                       flags_out,     // flag byte to store
   output logic                             flags_we,      // store flags_out
   output clr_dec_pkg::addr_mode_t          dst_mode,      // mode of the running op
   output logic                             busy,          // instruction in flight
   output logic                             illegal        // unknown opcode seen
);
   // elaboration checks: the datapath is byte wide and the cycle count is 3 bits
   if (DATA_W != 8) begin : g_width_check
      $error("only 8-bit data is served");
   end
   if (clr_dec_pkg::INSTR_CYCLES > 7) begin : g_cycle_check
      $error("cycle count does not fit the 3-bit counter");
   end

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   // resolve an operand byte into a full register address [RL2]
   function automatic logic [7:0] resolve(input logic [7:0] b, input logic [3:0] base);
      if (b[7:4] == clr_dec_pkg::WORK_PREFIX) begin
         // 4-bit working register number; the block base is 16-aligned, so
         // even/odd neighbours stay adjacent and pair into 16-bit values [RL3]
         resolve = {base, b[3:0]};
      end else begin
         resolve = b;                // full 0-255 address, peripherals included [RL4]
      end
   endfunction

   // -------------------------------------------------------------
   // sequencer
   // -------------------------------------------------------------
   typedef enum logic [1:0] {S_OPC, S_DST, S_PTR, S_WB} state_t;
   state_t              st_reg, st_next;
   logic                is_dec_reg, is_dec_next;       // minus one, else zero fill
   logic [7:0]          addr_reg, addr_next;            // effective address
   logic [2:0]          cyc_reg, cyc_next;              // cycles used so far
   clr_dec_pkg::addr_mode_t mode_reg, mode_next;
   logic                ill_reg, ill_next;
   clr_dec_pkg::rf_write_t  wr_reg, wr_next;
   logic [7:0]          fl_reg, fl_next;
   logic                fwe_reg, fwe_next;
   logic [7:0]          dec_val;                         // operand minus one
   logic [7:0]          op_val;

   // next state and outputs of the sequencer
   always_comb begin
      st_next     = st_reg;
      is_dec_next = is_dec_reg;
      addr_next   = addr_reg;
      mode_next   = mode_reg;
      ill_next    = 1'b0;
      wr_next     = '0;
      fl_next     = fl_reg;
      fwe_next    = 1'b0;
      cyc_next    = (st_reg == S_OPC) ? 3'h0 : cyc_reg + 3'h1;
      prog_ready  = 1'b0;
      rf_rd_addr  = addr_reg;
      op_val      = rf_rd_data;
      dec_val     = op_val - clr_dec_pkg::BYTE_ONE;   // wraps 00 to FF [RL12] [RL9]
      case (st_reg)
         S_OPC: begin
            prog_ready = 1'b1;
            if (prog_valid) begin
               cyc_next = 3'h1;
               // decode [RL5] [RL7] [RL11]
               if (prog_byte == clr_dec_pkg::OPC_ZERO_FILL_R) begin
                  is_dec_next = 1'b0;
                  mode_next   = clr_dec_pkg::MODE_REGISTER;
                  st_next     = S_DST;
               end else if (prog_byte == clr_dec_pkg::OPC_ZERO_FILL_PTR) begin
                  is_dec_next = 1'b0;
                  mode_next   = clr_dec_pkg::MODE_POINTER_REGISTER;
                  st_next     = S_DST;
               end else if (prog_byte == clr_dec_pkg::OPC_MINUS_ONE_R) begin
                  is_dec_next = 1'b1;
                  mode_next   = clr_dec_pkg::MODE_REGISTER;
                  st_next     = S_DST;
               end else if (prog_byte == clr_dec_pkg::OPC_MINUS_ONE_PTR) begin
                  is_dec_next = 1'b1;
                  mode_next   = clr_dec_pkg::MODE_POINTER_REGISTER;
                  st_next     = S_DST;
               end else begin
                  ill_next = 1'b1;   // not this unit's opcode, byte dropped
                  cyc_next = 3'h0;
               end
            end
         end
         S_DST: begin
            // second byte of two [RL7] [RL11]
            prog_ready = 1'b1;
            if (prog_valid) begin
               addr_next = resolve(prog_byte, work_base);
               st_next   = S_PTR;
            end else begin
               cyc_next = cyc_reg;   // stall: wait for the byte
            end
         end
         S_PTR: begin
            // pointer mode reads the pointer and targets the register it names, the pointer is kept [RL8]
            if (mode_reg == clr_dec_pkg::MODE_POINTER_REGISTER) begin
               addr_next = rf_rd_data;
            end
            st_next = S_WB;
         end
         default: begin
            // write back on the fourth cycle [RL13]
            st_next       = S_OPC;
            wr_next.we    = 1'b1;
            wr_next.addr  = addr_reg;
            if (is_dec_reg) begin
               wr_next.data = dec_val;
               fwe_next     = 1'b1;
               fl_next      = flags_in;   // C D H kept as found [RL10] [RL13]
               fl_next[clr_dec_pkg::FLAG_Z] = (dec_val == clr_dec_pkg::BYTE_ZERO);
               fl_next[clr_dec_pkg::FLAG_S] = dec_val[clr_dec_pkg::MSB];   // [RL1]
               // only 80 minus one overflows into 7F [RL12]
               fl_next[clr_dec_pkg::FLAG_V] = op_val[clr_dec_pkg::MSB] &
                                              ~dec_val[clr_dec_pkg::MSB];
            end else begin
               wr_next.data = clr_dec_pkg::BYTE_ZERO;   // flags not written [RL6]
            end
         end
      endcase
   end

   // register the sequencer
   always_ff @(posedge clk) begin
      if (reset) begin
         st_reg     <= S_OPC;
         is_dec_reg <= 1'b0;
         addr_reg   <= 8'h00;
         mode_reg   <= clr_dec_pkg::MODE_REGISTER;
         ill_reg    <= 1'b0;
         wr_reg     <= '0;
         fl_reg     <= 8'h00;
         fwe_reg    <= 1'b0;
         cyc_reg    <= 3'h0;
      end else begin
         st_reg     <= st_next;
         is_dec_reg <= is_dec_next;
         addr_reg   <= addr_next;
         mode_reg   <= mode_next;
         ill_reg    <= ill_next;
         wr_reg     <= wr_next;
         fl_reg     <= fl_next;
         fwe_reg    <= fwe_next;
         cyc_reg    <= cyc_next;
      end
   end

   assign rf_wr     = wr_reg;
   assign flags_out = fl_reg;
   assign flags_we  = fwe_reg;
   assign dst_mode  = mode_reg;
   assign illegal   = ill_reg;
   assign busy      = (st_reg != S_OPC);

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   // destination accept to the edge that samples the write strobe, no stall
   localparam int WB_LAT = clr_dec_pkg::INSTR_CYCLES - 1;

   sequence s_accept_zero;
      st_reg == S_OPC && prog_valid && prog_byte[7:1] == clr_dec_pkg::OPC_ZERO_FILL_R[7:1];
   endsequence
   sequence s_accept_dec;
      st_reg == S_OPC && prog_valid && prog_byte[7:1] == clr_dec_pkg::OPC_MINUS_ONE_R[7:1];
   endsequence

   property p_zero_writes_zero;
      @(posedge clk) disable iff (reset)
      s_accept_zero ##1 (prog_valid [*1]) ##2 1'b1 |=> rf_wr.we && rf_wr.data == 8'h00;
   endproperty
   a_zero_writes_zero: assert property (p_zero_writes_zero) else $error("zero fill bad"); // [RL6]

   property p_zero_no_flags;
      @(posedge clk) disable iff (reset)
      rf_wr.we && !is_dec_reg |-> !flags_we;
   endproperty
   a_zero_no_flags: assert property (p_zero_no_flags) else $error("zero fill wrote flags"); // [RL6]

   property p_four_cycles;
      @(posedge clk) disable iff (reset)
      (s_accept_zero or s_accept_dec) ##1 prog_valid |-> ##WB_LAT rf_wr.we;
   endproperty
   a_four_cycles: assert property (p_four_cycles) else $error("write not in four cycles"); // [RL7]

   // the cycle counter stands at the stated count exactly when the write shows
   property p_cycle_count;
      @(posedge clk) disable iff (reset)
      rf_wr.we |-> cyc_reg == clr_dec_pkg::INSTR_CYCLES;
   endproperty
   a_cycle_count: assert property (p_cycle_count) else $error("cycle count off"); // [RL13]

   property p_dec_value;
      @(posedge clk) disable iff (reset)
      st_reg == S_WB && is_dec_reg |=> rf_wr.data == $past(rf_rd_data) - 8'h01;
   endproperty
   a_dec_value: assert property (p_dec_value) else $error("minus one value bad"); // [RL9]

   property p_dec_flags_kept;
      @(posedge clk) disable iff (reset)
      st_reg == S_WB && is_dec_reg |=> flags_we &&
         flags_out[7] == $past(flags_in[7]) && flags_out[3:2] == $past(flags_in[3:2]);
   endproperty
   a_dec_flags_kept: assert property (p_dec_flags_kept) else $error("C D H changed"); // [RL10]

   property p_dec_zero;
      @(posedge clk) disable iff (reset)
      flags_we |-> flags_out[6] == (rf_wr.data == 8'h00) && flags_out[5] == rf_wr.data[7];
   endproperty
   a_dec_zero: assert property (p_dec_zero) else $error("Z or S wrong"); // [RL10]

   property p_overflow;
      @(posedge clk) disable iff (reset)
      flags_we |-> flags_out[4] == (rf_wr.data == 8'h7F);
   endproperty
   a_overflow: assert property (p_overflow) else $error("V wrong"); // [RL12]

   property p_ptr_target;
      @(posedge clk) disable iff (reset)
      st_reg == S_PTR && mode_reg == clr_dec_pkg::MODE_POINTER_REGISTER
         |=> ##1 rf_wr.we && rf_wr.addr == $past(rf_rd_data, 2);
   endproperty
   a_ptr_target: assert property (p_ptr_target) else $error("pointer target wrong"); // [RL8]
endmodule

// File: testbench/rf_model.sv
/*
 * behavioural register file and flag byte standing behind the unit.
 * assumes the bench preloads mem and flags by hierarchical reference.
 */
`timescale 1ns/1ps
module rf_model (
   input  wire logic                   clk,
   input  wire logic [7:0]             rd_addr,
   output logic [7:0]                  rd_data,
   input  wire clr_dec_pkg::rf_write_t wr,
   input  wire logic [7:0]             flags_out,
   input  wire logic                   flags_we,
   output logic [7:0]                  flags
);
   // ----------------------------------------------------------
   // storage
   // ----------------------------------------------------------
   logic [7:0] mem [256];  // flat space, peripherals included
   // same-cycle read, as the unit expects
   assign rd_data = mem[rd_addr];
   // writes land on the edge that samples the pulse
   always @(posedge clk) begin
      if (wr.we === 1'b1) mem[wr.addr] <= wr.data;
      if (flags_we === 1'b1) flags <= flags_out;
   end
endmodule

// File: testbench/tb.sv
/*
 * self-checking bench for the clear / decrement unit.
 * assumes rf_model answers reads combinationally and stores on the edge.
 */
`timescale 1ns/1ps
module tb;
   // ----------------------------------------------------------
   // signals
   // ----------------------------------------------------------
   typedef struct {time t; logic [7:0] a, d, f; logic fw; clr_dec_pkg::addr_mode_t m;} exp_t;
   logic                    clk = 1'b0;
   logic                    reset = 1'b1;
   logic                    prog_valid = 1'b0;
   logic [7:0]              prog_byte = 8'h00;
   logic [3:0]              work_base = 4'h0;
   logic                    prog_ready, flags_we, busy, illegal;
   logic [7:0]              rf_rd_addr, rf_rd_data, flags_in, flags_out;
   clr_dec_pkg::rf_write_t  rf_wr;
   clr_dec_pkg::addr_mode_t dst_mode;
   int                      mismatches = 0;
   int                      compares = 0;
   exp_t                    q[$];  // expected writes, oldest first
   logic [7:0]              tbl [4] = '{8'hB0, 8'hB1, 8'h00, 8'h01};
   always #10 clk = ~clk;
   // ----------------------------------------------------------
   // instances
   // ----------------------------------------------------------
   clear_decrement_exec_unit dut (.clk(clk), .reset(reset), .prog_valid(prog_valid),
      .prog_byte(prog_byte), .prog_ready(prog_ready), .work_base(work_base),
      .rf_rd_addr(rf_rd_addr), .rf_rd_data(rf_rd_data), .rf_wr(rf_wr), .flags_in(flags_in),
      .flags_out(flags_out), .flags_we(flags_we), .dst_mode(dst_mode), .busy(busy),
      .illegal(illegal));
   rf_model p (.clk(clk), .rd_addr(rf_rd_addr), .rd_data(rf_rd_data), .wr(rf_wr),
      .flags_out(flags_out), .flags_we(flags_we), .flags(flags_in));
   // ----------------------------------------------------------
   // checking tasks
   // ----------------------------------------------------------
   task automatic final_report();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic cmp_bit(input logic got, input logic want, input string msg);
      compares++;
      if (got !== want) begin
         mismatches++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask
   // time, target, value, flags and mode of one write
   task automatic cmp_wr(input exp_t e);
      compares++;
      if (!($time == e.t && rf_wr.addr === e.a && rf_wr.data === e.d && flags_we === e.fw
            && (!e.fw || flags_out === e.f) && dst_mode === e.m)) begin
         mismatches++;
         $display("MISMATCH %0t write %h %h", $time, rf_wr.addr, rf_wr.data);
      end
   endtask
   // ----------------------------------------------------------
   // driver: offer a byte until taken, bounded
   // ----------------------------------------------------------
   task automatic send(input logic [7:0] b, input logic [3:0] wb);
      int i;
      @(negedge clk);
      prog_valid = 1'b1;
      prog_byte = b;
      work_base = wb;
      for (i = 0; i < 20 && prog_ready !== 1'b1; i++) @(negedge clk);
      if (i == 20) begin
         mismatches++;
         final_report();
      end
      @(posedge clk);
   endtask
   // one instruction; the note is made once the prior write has landed
   task automatic op(input logic [7:0] opc, input logic [3:0] wb, input logic [7:0] d);
      exp_t e;
      logic [7:0] a, v;
      send(opc, wb);
      e.t = $time + (clr_dec_pkg::INSTR_CYCLES - 1) * 20 + 10;  // write seen three edges later
      send(d, wb);
      #1 cmp_bit(busy, 1'b1, "idle mid instruction");
      a = (d[7:4] == clr_dec_pkg::WORK_PREFIX) ? {wb, d[3:0]} : d;
      e.a = opc[0] ? p.mem[a] : a;  // pointer form follows the pointer
      v = p.mem[e.a];
      e.d = opc[7] ? 8'h00 : v - 8'h01;
      e.fw = !opc[7];
      e.f = {flags_in[7], e.d == 8'h00, e.d[7], v == 8'h80, flags_in[3:0]};
      e.m = opc[0] ? clr_dec_pkg::MODE_POINTER_REGISTER : clr_dec_pkg::MODE_REGISTER;
      q.push_back(e);
   endtask
   // ----------------------------------------------------------
   // monitor: every write pulse takes the oldest note
   // ----------------------------------------------------------
   always @(negedge clk) begin
      if (!reset && rf_wr.we === 1'b1) begin
         cmp_bit(busy, 1'b0, "busy at write");
         if (q.size() == 0) cmp_bit(1'b1, 1'b0, "unexpected write");
         else cmp_wr(q.pop_front());
      end else if (!reset) cmp_bit(flags_we, 1'b0, "lone flag write");
   end
   // watchdog on the whole run
   initial begin
      #(60000 * 20);
      mismatches++;
      final_report();
   end
   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial begin
      int i;
      void'($urandom(59771));
      for (i = 0; i < 256; i++) p.mem[i] = 8'($urandom);
      p.flags = 8'($urandom);
      repeat (10) @(posedge clk);
      @(negedge clk) reset = 1'b0;
      cmp_bit(prog_ready, 1'b1, "ready after reset");
      cmp_bit(busy, 1'b0, "busy after reset");
      p.mem[8'h10] = 8'h5A;
      op(8'hB0, 4'h0, 8'h10);
      p.mem[8'h21] = 8'h33;
      op(8'hB1, 4'h0, 8'h21);
      p.mem[8'h40] = 8'h00;
      op(8'h00, 4'h0, 8'h40);
      p.mem[8'h41] = 8'h80;
      op(8'h00, 4'h0, 8'h41);
      p.mem[8'h42] = 8'h01;
      op(8'h00, 4'h0, 8'h42);
      p.mem[8'h75] = 8'h44;
      op(8'h00, 4'h7, 8'hC5);
      p.mem[8'h76] = 8'h50;
      op(8'h01, 4'h7, 8'hC6);
      send(8'h5A, 4'h0);
      @(negedge clk);
      cmp_bit(illegal, 1'b1, "unknown opcode not flagged");
      repeat (40) op(tbl[$urandom % 4], 4'($urandom), 8'($urandom));
      @(negedge clk) prog_valid = 1'b0;
      for (i = 0; i < 20 && q.size() > 0; i++) @(negedge clk);
      cmp_bit(q.size() == 0, 1'b1, "missing writes");
      final_report();
   end
endmodule
